// ### hw/cer_defines.vh
// cer_defines.vh: codes, alarm numbers and timing for the card error and alarm reporter.
// assumes inclusion by bare name from the design file; definitions only.
`ifndef CER_DEFINES_VH
`define CER_DEFINES_VH

// ==========================================================
// card error codes
`define CER_E_INSERT      7'h01
`define CER_E_WPROT       7'h02
`define CER_E_RPROT       7'h03
`define CER_E_FULL        7'h06
`define CER_E_BUSY        7'h07
`define CER_E_FWPROT      7'h08
`define CER_E_ACCESS      7'h09
`define CER_E_SEQ         7'h0b
`define CER_E_SEQ_FILE    7'h0e
`define CER_E_BATT_WARN   7'h0f
`define CER_E_VERSION     7'h10
`define CER_E_MISSING     7'h11
`define CER_E_DEV_FULL    7'h12
`define CER_E_DEV_HW      7'h13
`define CER_E_INVALID     7'h14
`define CER_E_PROG_SUM    7'h15
`define CER_E_PAR_SUM_LO  7'h16
`define CER_E_PAR_SUM_HI  7'h24
`define CER_E_LOAD_PROT   7'h25
`define CER_E_NO_SPARE    7'h2b
`define CER_E_SPARE_WR    7'h2c
`define CER_E_BATT_ERR    7'h3f
`define CER_E_PULLED      7'h40

// ==========================================================
// card fault input bit positions
`define CER_F_INSERT      0
`define CER_F_WPROT       1
`define CER_F_RPROT       2
`define CER_F_FULL        3
`define CER_F_BUSY        4
`define CER_F_FWPROT      5
`define CER_F_ACCESS      6
`define CER_F_SEQ         7
`define CER_F_SEQ_FILE    8
`define CER_F_BATT_WARN   9
`define CER_F_VERSION     10
`define CER_F_MISSING     11
`define CER_F_DEV_FULL    12
`define CER_F_DEV_HW      13
`define CER_F_INVALID     14
`define CER_F_NO_SPARE    15
`define CER_F_SPARE_WR    16
`define CER_F_BATT_ERR    17
`define CER_F_PULLED      18
`define CER_NFAULT        19

// ==========================================================
// alarm numbers, bit index = position in alarm vector
`define CER_AL_PV1_OVER   7'h01
`define CER_AL_PV1_UNDER  7'h02
`define CER_AL_BOARD      7'h5a
`define CER_AL_ADJUST     7'h5c
`define CER_AL_PARAM      7'h5e
`define CER_AL_PROG       7'h60
`define CER_AL_PROM       7'h63
`define CER_NALARM        7

// ==========================================================
// analog input limits, per mille of span (-10.0% and +110.0%)
`define CER_AI_LOW        -100
`define CER_AI_HIGH       1100

// ==========================================================
// timing
`define CER_CLK_HZ        250000000
`define CER_ALT_MS        1000

`endif

// ### hw/cer_reporter.v
// cer_reporter.v: card error reporting, self-diagnostic alarms and display rotation.
// assumes synchronous inputs on clk, one-cycle key pulses, and a power-on reset pulse.
// Behaviour
// - card failure shows numeric error code
// - a card error aborts card operation unless one is already held
// - return key clears error, normal display
// - codes 1,2,3: insertion, write/read protect
// - codes 6,7,8: full, busy, file protect
// - codes 9,11,14: access and sequence errors
// - card battery: 15 warning, 63 error
// - codes 16,17,20: version, missing, invalid
// - load: 18 device full, 19 hardware
// - checksum mismatch: 21 program, 22-36 parameters
// - nonzero load protect refuses load, 37
// - spare areas: 43 none, 44 write fail
// - card pulled during access: code 64
// - power-on memory fail: silent general reset
// - power-on board mismatch raises alarm
// - analog input out of range alarms
// - continuous memory and data checks alarm
// - low backup battery lights indicator
// - alarm alternates with normal each second
// - multiple alarms shown in ascending order
// - autoload selection accepts only 1, 0
// - load key: menu or automatic load
// - first process value overrange alarm
`timescale 1ns/1ps
`include "cer_defines.vh"

module cer_reporter #(
    parameter integer CLK_HZ  = `CER_CLK_HZ,
    parameter integer ALT_MS  = `CER_ALT_MS,
    parameter integer AI_W    = 16,
    parameter integer PAR_W   = 8
) (
    // clock and reset
    input  wire              clk,
    input  wire              reset,
    // operator keys, one-cycle pulses
    input  wire              display_return_key,
    input  wire              load_key,
    // parameters
    input  wire [PAR_W-1:0]  load_protect_param,
    input  wire              autoload_param_wr,
    input  wire [PAR_W-1:0]  autoload_param_wdata,
    // card side
    input  wire              card_busy_op,
    input  wire              card_loading,
    input  wire [`CER_NFAULT-1:0] card_fault,
    input  wire              sum_check_done,
    input  wire              sum_is_program,
    input  wire [3:0]        sum_param_index,
    input  wire              sum_mismatch,
    // self-check sources
    input  wire              por_check_done,
    input  wire              backup_ram_ok,
    input  wire              board_config_ok,
    input  wire              sample_tick,
    input  wire signed [AI_W-1:0] first_process_value,
    input  wire              prom_fail,
    input  wire              adjust_fail,
    input  wire              prog_fail,
    input  wire              param_fail,
    input  wire              backup_batt_low,
    // outputs
    output reg               card_abort,
    output reg               card_error_shown,
    output reg  [6:0]        card_error_code,
    output reg               general_reset,
    output reg               battery_low_indicator,
    output reg               panel1_show_alarm,
    output reg  [6:0]        panel1_alarm_code,
    output reg               autoload_select_param,
    output reg               open_load_menu,
    output reg               start_autoload,
    output reg  [`CER_NALARM-1:0] alarm_active
);

    // ==========================================================
    // timing constants
    localparam integer ALT_CYCLES = (CLK_HZ / 1000) * ALT_MS;
    localparam integer PS_W       = 32;

    // display states, one-hot
    localparam [1:0] ST_NORMAL = 2'b01;
    localparam [1:0] ST_ALARM  = 2'b10;

    // ==========================================================
    // code lookup for a card fault bit
    // codes 4, 5 and 12 have no fault source on these ports
    function [6:0] fault_code;
        input integer idx;
        begin
            case (idx)
                `CER_F_INSERT:    fault_code = `CER_E_INSERT;
                `CER_F_WPROT:     fault_code = `CER_E_WPROT;
                `CER_F_RPROT:     fault_code = `CER_E_RPROT;
                `CER_F_FULL:      fault_code = `CER_E_FULL;
                `CER_F_BUSY:      fault_code = `CER_E_BUSY;
                `CER_F_FWPROT:    fault_code = `CER_E_FWPROT;
                `CER_F_ACCESS:    fault_code = `CER_E_ACCESS;
                `CER_F_SEQ:       fault_code = `CER_E_SEQ;
                `CER_F_SEQ_FILE:  fault_code = `CER_E_SEQ_FILE;
                `CER_F_BATT_WARN: fault_code = `CER_E_BATT_WARN;
                `CER_F_VERSION:   fault_code = `CER_E_VERSION;
                `CER_F_MISSING:   fault_code = `CER_E_MISSING;
                `CER_F_DEV_FULL:  fault_code = `CER_E_DEV_FULL;
                `CER_F_DEV_HW:    fault_code = `CER_E_DEV_HW;
                `CER_F_INVALID:   fault_code = `CER_E_INVALID;
                `CER_F_NO_SPARE:  fault_code = `CER_E_NO_SPARE;
                `CER_F_SPARE_WR:  fault_code = `CER_E_SPARE_WR;
                `CER_F_BATT_ERR:  fault_code = `CER_E_BATT_ERR;
                `CER_F_PULLED:    fault_code = `CER_E_PULLED;
                default:          fault_code = 7'h00;
            endcase
        end
    endfunction

    // alarm number for an alarm vector index
    function [6:0] alarm_num;
        input integer idx;
        begin
            case (idx)
                0:       alarm_num = `CER_AL_PV1_OVER;
                1:       alarm_num = `CER_AL_PV1_UNDER;
                2:       alarm_num = `CER_AL_BOARD;
                3:       alarm_num = `CER_AL_ADJUST;
                4:       alarm_num = `CER_AL_PARAM;
                5:       alarm_num = `CER_AL_PROG;
                6:       alarm_num = `CER_AL_PROM;
                default: alarm_num = 7'h00;
            endcase
        end
    endfunction

    // ==========================================================
    // card fault priority: lowest bit index wins when several arrive together
    reg  [6:0] new_code;
    reg        new_err;
    integer    i;

    always @* begin
        new_code = 7'h00;
        new_err  = 1'b0;

        // card lines may float while idle, so they are gated
        for (i = `CER_NFAULT - 1; i >= 0; i = i - 1) begin
            if (card_busy_op && card_fault[i]) begin
                new_err  = 1'b1;
                new_code = fault_code(i);
            end
        end

        // checksum result comes after the fault bits so explicit faults take precedence
        if (!new_err && card_busy_op && sum_check_done && sum_mismatch) begin
            new_err = 1'b1;
            if (sum_is_program)
                new_code = `CER_E_PROG_SUM;
            else if (sum_param_index <= (`CER_E_PAR_SUM_HI - `CER_E_PAR_SUM_LO))
                new_code = `CER_E_PAR_SUM_LO + {3'h0, sum_param_index};
            else
                new_code = `CER_E_PAR_SUM_HI;
        end

        // load refused while protection parameter is nonzero
        if (!new_err && card_loading && (load_protect_param != {PAR_W{1'b0}})) begin
            new_err  = 1'b1;
            new_code = `CER_E_LOAD_PROT;
        end
    end

    // ==========================================================
    // card error latch
    reg [6:0] code_q;
    reg       shown_q;

    always @(posedge clk) begin
        if (reset) begin
            code_q           <= 7'h00;
            shown_q          <= 1'b0;
            card_abort       <= 1'b0;
            card_error_shown <= 1'b0;
            card_error_code  <= 7'h00;
        end else begin
            // a new error wins over a return key in the same cycle
            if (new_err && !shown_q) begin
                shown_q <= 1'b1;
                code_q  <= new_code;
            end else if (display_return_key) begin
                shown_q <= 1'b0;
                code_q  <= 7'h00;
            end

            // an error during a held one is not shown: first cause kept
            card_abort       <= new_err && !shown_q;
            card_error_shown <= shown_q;
            card_error_code  <= code_q;
        end
    end

    // ==========================================================
    // load key routing and autoload selection
    always @(posedge clk) begin
        if (reset) begin
            autoload_select_param <= 1'b0;
            open_load_menu        <= 1'b0;
            start_autoload        <= 1'b0;
        end else begin
            // values other than 0 or 1 are ignored
            if (autoload_param_wr && (autoload_param_wdata[PAR_W-1:1] == {(PAR_W-1){1'b0}}))
                autoload_select_param <= autoload_param_wdata[0];

            // no load starts while an error is held
            open_load_menu <= load_key && !shown_q && !autoload_select_param;
            start_autoload <= load_key && !shown_q && autoload_select_param;
        end
    end

    // ==========================================================
    // self-diagnostics
    reg [`CER_NALARM-1:0] alarm_q;

    always @(posedge clk) begin
        if (reset) begin
            alarm_q               <= {`CER_NALARM{1'b0}};
            general_reset         <= 1'b0;
            battery_low_indicator <= 1'b0;
            alarm_active          <= {`CER_NALARM{1'b0}};
        end else begin
            // no alarm bit for memory failure: it only resets stored data
            general_reset <= por_check_done && !backup_ram_ok;

            // sticky: a board mismatch needs a restart to heal
            if (por_check_done && !board_config_ok)
                alarm_q[2] <= 1'b1;

            if (sample_tick) begin
                alarm_q[0] <= (first_process_value > `CER_AI_HIGH);
                alarm_q[1] <= (first_process_value < `CER_AI_LOW);
            end

            // continuous checks track their sources level by level
            alarm_q[3] <= adjust_fail;
            alarm_q[4] <= param_fail;
            alarm_q[5] <= prog_fail;
            alarm_q[6] <= prom_fail;

            battery_low_indicator <= backup_batt_low;
            alarm_active          <= alarm_q;
        end
    end

    // ==========================================================
    // one-second prescaler
    reg [PS_W-1:0] ps_q;
    reg            sec_tick;

    // one-cycle enable; a small ALT_MS only shortens simulation
    always @(posedge clk) begin
        if (reset) begin
            ps_q     <= {PS_W{1'b0}};
            sec_tick <= 1'b0;
        end else if (ps_q == ALT_CYCLES[PS_W-1:0] - 1'b1) begin
            ps_q     <= {PS_W{1'b0}};
            sec_tick <= 1'b1;
        end else begin
            ps_q     <= ps_q + 1'b1;
            sec_tick <= 1'b0;
        end
    end

    // ==========================================================
    // next active alarm above the one last shown, wrapping to the lowest
    reg  [2:0] cur_q;
    reg  [2:0] next_idx;
    reg        next_ok;
    integer    k;

    always @* begin
        next_idx = 3'h0;
        next_ok  = 1'b0;
        for (k = `CER_NALARM - 1; k >= 0; k = k - 1) begin
            if (alarm_q[k] && (k > cur_q)) begin
                next_ok  = 1'b1;
                next_idx = k[2:0];
            end
        end

        // nothing above the last one shown: wrap to the lowest
        if (!next_ok) begin
            for (k = `CER_NALARM - 1; k >= 0; k = k - 1) begin
                if (alarm_q[k]) begin
                    next_ok  = 1'b1;
                    next_idx = k[2:0];
                end
            end
        end
    end

    // ==========================================================
    // panel 1 rotation: normal, alarm, normal, next alarm ...
    reg [1:0] st_q;

    always @(posedge clk) begin
        if (reset) begin
            st_q              <= ST_NORMAL;
            cur_q             <= 3'h7;
            panel1_show_alarm <= 1'b0;
            panel1_alarm_code <= 7'h00;
        end else begin
            case (st_q)
                ST_NORMAL: begin
                    if (sec_tick && next_ok) begin
                        st_q              <= ST_ALARM;
                        cur_q             <= next_idx;
                        panel1_show_alarm <= 1'b1;
                        panel1_alarm_code <= alarm_num(next_idx);
                    end

                    // no alarm left: next round starts at the lowest
                    if (!next_ok)
                        cur_q <= 3'h7;
                end
                ST_ALARM: begin
                    // ends early once the last alarm clears
                    if (sec_tick || !next_ok) begin
                        st_q              <= ST_NORMAL;
                        panel1_show_alarm <= 1'b0;
                        panel1_alarm_code <= 7'h00;
                    end
                end
                default: begin
                    st_q              <= ST_NORMAL;
                    panel1_show_alarm <= 1'b0;
                    panel1_alarm_code <= 7'h00;
                end
            endcase
        end
    end

endmodule // cer_reporter

// ### testbench/cer_reporter_assertions.sv
// cer_reporter_assertions.sv: port-level checks of the card error and alarm reporter.
// assumes it is bound to cer_reporter and sees only that module's ports.
`timescale 1ns/1ps
// ==========================================================
// checker
module cer_reporter_assertions (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // keys and check sources
    input wire logic       display_return_key,
    input wire logic       load_key,
    input wire logic       autoload_param_wr,
    input wire logic       por_check_done,
    input wire logic       backup_ram_ok,
    input wire logic       prom_fail,
    input wire logic       backup_batt_low,
    // outputs under check
    input wire logic       card_abort,
    input wire logic       card_error_shown,
    input wire logic [6:0] card_error_code,
    input wire logic       general_reset,
    input wire logic       battery_low_indicator,
    input wire logic       panel1_show_alarm,
    input wire logic [6:0] panel1_alarm_code,
    input wire logic       autoload_select_param,
    input wire logic       open_load_menu,
    input wire logic       start_autoload,
    input wire logic [6:0] alarm_active
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);

    a_abort_then_shown: assert property (card_abort |=> card_error_shown && !card_abort)
        else $error("abort not followed by a shown error");
    a_shown_has_code: assert property (card_error_shown |-> card_error_code != 7'h00)
        else $error("error shown without a code");
    a_code_latched: assert property (card_error_shown && !display_return_key
        && !$past(display_return_key) |=> card_error_shown && $stable(card_error_code))
        else $error("error code changed before the return key");
    a_return_clears: assert property (display_return_key && card_error_shown
        |-> ##2 !card_error_shown) else $error("return key did not clear the error");
    a_load_menu: assert property (load_key && !card_error_shown && !card_abort
        && !autoload_param_wr && !autoload_select_param |=> open_load_menu && !start_autoload)
        else $error("load key did not open the menu");
    a_load_auto: assert property (load_key && !card_error_shown && !card_abort
        && !autoload_param_wr && autoload_select_param |=> start_autoload && !open_load_menu)
        else $error("load key did not start an automatic load");
    a_silent_reset: assert property (por_check_done && !backup_ram_ok |=> general_reset)
        else $error("memory check failure gave no general reset");
    a_batt_follow: assert property (!$past(reset)
        |-> battery_low_indicator == $past(backup_batt_low))
        else $error("battery indicator does not follow the battery");
    a_prom_alarm: assert property (prom_fail |-> ##2 alarm_active[6])
        else $error("memory failure raised no alarm");
    a_board_sticky: assert property (alarm_active[2] |=> alarm_active[2])
        else $error("board alarm dropped before reset");
    a_panel_idle: assert property (!panel1_show_alarm |-> panel1_alarm_code == 7'h00)
        else $error("alarm code shown in the normal phase");
endmodule // cer_reporter_assertions

// ### testbench/cer_card_model.sv
// cer_card_model.sv: behavioural memory card, runs one operation per go pulse.
// assumes bench commands change just after clk; the device answers with card_abort.
`timescale 1ns/1ps
// ==========================================================
// card model
module cer_card_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // bench commands
    input  wire logic        go,
    input  wire logic [1:0]  kind,
    input  wire logic [18:0] fmask,
    input  wire logic [3:0]  pidx,
    input  wire logic [3:0]  dly,
    input  wire logic        ld,
    // device side
    input  wire logic        card_abort,
    output logic             card_busy_op,
    output logic             card_loading,
    output logic [18:0]      card_fault,
    output logic             sum_check_done,
    output logic             sum_is_program,
    output logic [3:0]       sum_param_index,
    output logic             sum_mismatch
);
    logic [4:0] cnt_q;
    logic [7:0] pat_q;
    logic       ev;
    assign ev = card_busy_op && cnt_q == 5'h08;
    // idle fault and checksum data lines follow a running pattern so stale values cannot pass for real ones
    assign card_fault = (ev && kind == 2'h0) ? fmask :
                        card_busy_op ? 19'h0 : {pat_q[2:0], pat_q, pat_q};
    assign sum_check_done  = ev && kind[0] != kind[1];
    assign sum_is_program  = ev ? kind == 2'h1 : pat_q[0];
    assign sum_param_index = ev ? pidx : pat_q[3:0];
    assign sum_mismatch    = ev | pat_q[1];
    always @(posedge clk) begin
        if (reset) begin
            card_busy_op <= 1'b0;
            card_loading <= 1'b0;
            cnt_q        <= 5'h00;
            pat_q        <= 8'h5a;
        end else begin
            pat_q <= pat_q + 8'h35;
            if (!card_busy_op) begin
                card_busy_op <= go;
                card_loading <= go & ld;
                cnt_q        <= {1'b0, dly} + 5'h08;
            end else if (card_abort || cnt_q == 5'h00) begin
                card_busy_op <= 1'b0;
                card_loading <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule // cer_card_model

// ### testbench/cer_reporter_tb.sv
// cer_reporter_tb.sv: self-checking bench for the card error and alarm reporter.
// assumes the card model drives the card side; one alternation phase is 8 cycles.
`timescale 1ns/1ps
// ==========================================================
// bench
module cer_reporter_tb;
    logic              clk, reset, display_return_key, load_key, autoload_param_wr, go, ld;
    logic              sample_tick, por_check_done, backup_ram_ok, board_config_ok;
    logic              prom_fail, adjust_fail, prog_fail, param_fail, backup_batt_low;
    logic [7:0]        load_protect_param, autoload_param_wdata;
    logic signed [15:0] first_process_value;
    logic [1:0]        kind;
    logic [3:0]        pidx, dly;
    logic [18:0]       fmask;
    wire               card_busy_op, card_loading, sum_check_done, sum_is_program;
    wire               sum_mismatch, card_abort, card_error_shown, general_reset;
    wire               battery_low_indicator, panel1_show_alarm, autoload_select_param;
    wire               open_load_menu, start_autoload;
    wire [18:0]        card_fault;
    wire [3:0]         sum_param_index;
    wire [6:0]         card_error_code, panel1_alarm_code, alarm_active;
    integer            seed, rnd, miscompares, cmp_count, ab_count, gr_count, n_err;
    integer            i, a, b, nrm, first;
    logic              was, shown_q;
    logic [6:0]        nxt;
    logic [6:0]        eq[$];
    logic [1:0]        lq[$];
    logic [6:0]        codes[0:18] = '{7'h01, 7'h02, 7'h03, 7'h06, 7'h07, 7'h08, 7'h09,
        7'h0b, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h2b, 7'h2c, 7'h3f, 7'h40};

    cer_reporter #(.CLK_HZ(1000), .ALT_MS(8)) cer_reporter_inst (.*);
    cer_card_model cer_card_model_inst (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task chk(input [31:0] seen, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one card operation; the return key is pressed afterwards in every case
    task op(input [18:0] m, input [1:0] k, input [3:0] p, input l, input [6:0] e);
        integer j;
        if (e != 7'h00) eq.push_back(e);
        if (e != 7'h00) n_err = n_err + 1;
        rnd = $random(seed);
        @(posedge clk);
        fmask <= m; kind <= k; pidx <= p; ld <= l; dly <= rnd[3:0]; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (j = 0; j < 40 && card_busy_op === 1'b1; j = j + 1) @(posedge clk);
        repeat (3) @(posedge clk);
        chk(card_error_shown, e != 7'h00);
        display_return_key <= 1'b1;
        @(posedge clk);
        display_return_key <= 1'b0;
        repeat (3) @(posedge clk);
        chk(card_error_shown, 1'b0);
    endtask

    task aw(input [7:0] v, input e);
        @(posedge clk);
        autoload_param_wr <= 1'b1; autoload_param_wdata <= v;
        @(posedge clk);
        autoload_param_wr <= 1'b0;
        @(posedge clk);
        chk(autoload_select_param, e);
    endtask

    task lk(input [1:0] e);
        lq.push_back(e);
        @(posedge clk);
        load_key <= 1'b1;
        @(posedge clk);
        load_key <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task pv(input signed [15:0] v, input [1:0] e);
        @(posedge clk);
        first_process_value <= v; sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        repeat (4) @(posedge clk);
        chk(alarm_active[1:0], e);
    endtask

    // result watcher: each result taken off the oldest note
    always @(posedge clk) begin
        shown_q <= card_error_shown;
        if (card_abort === 1'b1) ab_count = ab_count + 1;
        if (general_reset === 1'b1) gr_count = gr_count + 1;
        if (card_error_shown === 1'b1 && shown_q !== 1'b1)
            chk(card_error_code, eq.size() ? eq.pop_front() : 7'h7f);
        if ((open_load_menu | start_autoload) === 1'b1)
            chk({start_autoload, open_load_menu}, lq.size() ? lq.pop_front() : 2'h3);
    end

    initial begin
        #100000;
        miscompares = miscompares + 1;
        tally_and_finish;
    end

    initial begin
        seed = 32'he79d1bbb; miscompares = 0; cmp_count = 0; ab_count = 0; gr_count = 0;
        n_err = 0; reset = 1'b1; display_return_key = 1'b0; load_key = 1'b0; go = 1'b0;
        autoload_param_wr = 1'b0; autoload_param_wdata = 8'h00; load_protect_param = 8'h00;
        sample_tick = 1'b0; por_check_done = 1'b0; backup_ram_ok = 1'b1; ld = 1'b0;
        board_config_ok = 1'b1; prom_fail = 1'b0; adjust_fail = 1'b0; prog_fail = 1'b0;
        param_fail = 1'b0; backup_batt_low = 1'b0; first_process_value = 16'sh0000;
        kind = 2'h0; pidx = 4'h0; dly = 4'h0; fmask = 19'h0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 19; i = i + 1)
            op(19'h1 << i, '0, '0, '0, codes[i]);
        repeat (3) begin
            rnd = $random(seed) & 32'h7fffffff; a = rnd % 18;
            rnd = $random(seed) & 32'h7fffffff; b = a + 1 + rnd % (18 - a);
            op((19'h1 << a) | (19'h1 << b), 2'h0, 4'h0, 1'b0, codes[a]);
        end
        op(19'h0, 2'h1, 4'h0, 1'b0, 7'h15);
        for (i = 0; i < 16; i = i + 1)
            op(19'h0, 2'h2, i[3:0], 1'b0, i > 14 ? 7'h24 : 7'h16 + i[6:0]);
        rnd = $random(seed);
        load_protect_param <= rnd[7:0] | 8'h01;
        op(19'h0, 2'h3, 4'h0, 1'b1, 7'h25);
        op(19'h0, 2'h3, 4'h0, 1'b0, 7'h00);
        load_protect_param <= 8'h00;
        op(19'h0, 2'h3, 4'h0, 1'b1, 7'h00);
        aw(8'h05, 1'b0);
        lk(2'h1);
        aw(8'h01, 1'b1);
        aw(8'h02, 1'b1);
        lk(2'h2);
        aw(8'h00, 1'b0);
        lk(2'h1);
        backup_batt_low <= 1'b1;
        repeat (3) @(posedge clk);
        chk(battery_low_indicator, 1'b1);
        backup_batt_low <= 1'b0;
        por_check_done <= 1'b1; backup_ram_ok <= 1'b0; board_config_ok <= 1'b0;
        @(posedge clk);
        por_check_done <= 1'b0; backup_ram_ok <= 1'b1; board_config_ok <= 1'b1;
        repeat (4) @(posedge clk);
        chk(alarm_active, 7'h04);
        pv(16'sd1100, 2'h0);
        pv(-16'sd101, 2'h2);
        pv(-16'sd100, 2'h0);
        pv(16'sd1101, 2'h1);
        adjust_fail <= 1'b1; prog_fail <= 1'b1; param_fail <= 1'b1; prom_fail <= 1'b1;
        repeat (4) @(posedge clk);
        chk(alarm_active, 7'h7d);
        adjust_fail <= 1'b0; prog_fail <= 1'b0; param_fail <= 1'b0;
        repeat (4) @(posedge clk);
        chk(alarm_active, 7'h45);
        nrm = 0; first = 1; was = 1'b0; nxt = 7'h00;
        for (i = 0; i < 120; i = i + 1) begin
            @(posedge clk);
            if (panel1_show_alarm === 1'b1 && !was) begin
                if (!first) chk(nrm, 8);
                if (!first) chk(panel1_alarm_code, nxt);
                first = 0;
                nxt = panel1_alarm_code == 7'h01 ? 7'h5a :
                      panel1_alarm_code == 7'h5a ? 7'h63 : 7'h01;
            end
            nrm = panel1_show_alarm ? 0 : nrm + 1;
            was = panel1_show_alarm;
        end
        chk(first, 0);
        chk(eq.size() + lq.size(), 0);
        chk(ab_count, n_err);
        chk(gr_count, 1);
        tally_and_finish;
    end
endmodule // cer_reporter_tb

bind cer_reporter cer_reporter_assertions cer_reporter_assertions_inst (.*);
